// ### spiasc_pkg.sv
/*
 Package for the serial audio/SPI control block: register offsets, control
 field positions, reset values, word lengths, state codes and carrier types.
 Assumes a 32-bit register port with byte addresses on four address bits.
*/
`default_nettype none
package spiasc_pkg;
    localparam logic [3:0]  A_CTRL    = 4'h0;
    localparam logic [3:0]  A_DATA    = 4'h4;
    localparam logic [3:0]  A_BAUD    = 4'h8;
    localparam logic [3:0]  A_STAT    = 4'hc;
    localparam int          B_MCLK    = 23;
    localparam int          B_FEDGE   = 17;
    localparam int          B_EBUF    = 16;
    localparam int          B_ON      = 15;
    localparam int          B_ISTOP   = 13;
    localparam int          B_DOD     = 12;
    localparam int          B_W32     = 11;
    localparam int          B_W16     = 10;
    localparam int          B_SMP     = 9;
    localparam int          B_CKE     = 8;
    localparam int          B_AUD     = 7;
    localparam int          B_CKP     = 6;
    localparam int          B_MST     = 5;
    localparam int          B_FRM     = 4;
    localparam logic [31:0] CTRL_MASK = 32'h0083_bff0;
    localparam logic [31:0] LOCK_MASK = 32'h0081_0000;
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [15:0] BAUD_RST  = 16'h0001;
    localparam logic [5:0]  LEN8      = 6'h08;
    localparam logic [5:0]  LEN16     = 6'h10;
    localparam logic [5:0]  LEN24     = 6'h18;
    localparam logic [6:0]  LEN32     = 7'h20;
    localparam int          S_BUSY    = 0;
    localparam int          S_RXF     = 1;
    localparam int          S_TXF     = 2;
    localparam int          S_TXE     = 3;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_PRE   = 3'b010,
        ST_SHIFT = 3'b100
    } spiasc_state_t;

    typedef struct packed {
        logic mclk;
        logic fedge;
        logic ebuf;
        logic on;
        logic istop;
        logic dod;
        logic w32;
        logic w16;
        logic sample_phase;
        logic cke;
        logic aud;
        logic clock_polarity;
        logic mst;
        logic frm;
    } spiasc_ctrl_t;

    typedef struct packed {
        logic sck;
        logic sck_oe;
        logic sdo;
        logic sdo_oe;
        logic fs;
        logic fs_oe;
    } spiasc_pins_t;

    // Word length and channel length in bits; 7 bits wide so that 32 is held as LEN32
    typedef struct packed {
        logic [6:0] dlen;
        logic [6:0] chan;
    } spiasc_len_t;
endpackage
`default_nettype wire

// ### spiasc_core.sv
/*
 Serial port engine working as plain SPI, framed SPI or audio (two channel)
 serial link, with control, data, baud and status registers on a plain port.
 Assumes all pin inputs are synchronous to i_clk and that the reference
 clock arrives as a one-cycle enable pulse i_ref_clk_en.
*/
// Local design decisions: the address map and the plain strobed port.
// Contract
// [R1] Clock select 1 feeds the baud generator from the reference clock, 0 from the bus clock.
// [R2] In framed mode, frame edge 1 puts the sync pulse on the first bit, 0 one bit before it.
// [R3] The enhanced buffer bit switches the deeper transmit queue on or off.
// [R4] The module on bit enables the module; clearing it disables all of it.
// [R5] With idle stop set the module halts while the processor is idle.
// [R6] Data-out disable releases the data output pin; clear, the module drives it.
// [R7] In audio mode the width bits pick 24/32/64, 16/32/64 or 16/16/32 data/channel/frame.
// [R8] Outside audio mode the width bits pick 32, 16 or 8 bit words.
// [R9] As master, sample phase 1 samples at the end of the bit, 0 in its middle.
// [R10] As slave, input is always sampled in the middle of the bit.
// [R11] Clock edge 1 changes data on the active-to-idle edge, 0 on the idle-to-active edge.
// [R12] Clock select and enhanced buffer bits are writable only while the module is off.
// [R13] The clock edge bit is ignored in framed mode and should be written zero there.
// [R14] In audio mode the clock behaves as if polarity were 1.
// [R15] Clock polarity sets the idle level of the serial clock.
`timescale 1ns/10ps
`default_nettype none
module spiasc_core
    import spiasc_pkg::*;
#(
    parameter int TXQ_DEPTH = 4
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [3:0]   i_addr,
    input  wire logic [31:0]  i_wdata,
    input  wire logic         i_wr,
    input  wire logic         i_rd,
    output logic [31:0]       o_rdata,
    input  wire logic         i_ref_clk_en,
    input  wire logic         i_cpu_idle,
    input  wire logic         i_sck,
    input  wire logic         i_ss_n,
    input  wire logic         i_sdi,
    output spiasc_pins_t      o_pins
);
    localparam int QW = (TXQ_DEPTH > 1) ? $clog2(TXQ_DEPTH) : 1;
    localparam logic [QW:0] QCAP = QW'(TXQ_DEPTH) == '0 ? {1'b1, {QW{1'b0}}} : (QW+1)'(TXQ_DEPTH);

    function automatic spiasc_ctrl_t dec_ctrl(input logic [31:0] r);
        return '{r[B_MCLK], r[B_FEDGE], r[B_EBUF], r[B_ON], r[B_ISTOP], r[B_DOD],
                 r[B_W32], r[B_W16], r[B_SMP], r[B_CKE], r[B_AUD], r[B_CKP], r[B_MST], r[B_FRM]};
    endfunction

    function automatic spiasc_len_t widths(input spiasc_ctrl_t c);
        spiasc_len_t l;
        if (c.aud) begin
            l.dlen = c.w32 ? {1'b0, LEN24} : {1'b0, LEN16};
            l.chan = (c.w32 | c.w16) ? LEN32 : {1'b0, LEN16};
        end else begin
            l.dlen = c.w32 ? LEN32 : (c.w16 ? {1'b0, LEN16} : {1'b0, LEN8});
            l.chan = l.dlen;
        end
        return l;
    endfunction

    logic [31:0]   ctrl_q;
    logic [15:0]   baud_q;
    logic [15:0]   bcnt_q;
    logic [31:0]   q_mem [TXQ_DEPTH];
    logic [QW-1:0] wp_q;
    logic [QW-1:0] rp_q;
    logic [QW:0]   qcnt_q;
    spiasc_state_t st_q;
    logic          h_q;
    logic [6:0]    bit_q;
    logic [31:0]   sh_q;
    logic [31:0]   rsh_q;
    logic [31:0]   rx_q;
    logic          rxf_q;
    logic          ws_q;
    logic          first_q;
    logic          sckp_q;
    logic [31:0]   rdata_q;
    spiasc_pins_t  pins_q;

    spiasc_ctrl_t  c;
    spiasc_len_t   len;
    logic          ckp_eff;
    logic          cke_eff;
    logic          smp_eff;
    logic          halt;
    logic          run;
    logic          src_en;
    logic          tick;
    logic          wr_ctrl;
    logic          push;
    logic          pop;
    logic [QW:0]   cap;
    logic          lead_e;
    logic          trail_e;
    logic          samp;
    logic          shift;
    logic          last;
    logic          done;
    logic          start;
    logic [31:0]   rnext;
    logic [31:0]   dmask;

    assign c       = dec_ctrl(ctrl_q);
    assign len     = widths(c);
    assign ckp_eff = c.aud | c.clock_polarity; // R14
    assign cke_eff = c.cke & ~c.frm; // R13
    assign smp_eff = c.mst & c.sample_phase; // R10
    assign halt    = c.istop & i_cpu_idle; // R5
    assign run     = c.on & ~halt; // R4
    assign src_en  = c.mclk ? i_ref_clk_en : 1'b1; // R1
    assign tick    = run & c.mst & src_en & (bcnt_q == baud_q) & (st_q != ST_IDLE);
    assign wr_ctrl = i_wr & (i_addr == A_CTRL);
    assign cap     = c.ebuf ? QCAP : (QW+1)'(1); // R3
    assign push    = i_wr & (i_addr == A_DATA) & (qcnt_q < cap);
    assign last    = bit_q == (len.chan - 7'h01);
    assign dmask   = 32'hffff_ffff >> (LEN32 - len.dlen);

    // Slave clock edges, named against the effective idle level
    assign lead_e  = run & ~c.mst & (sckp_q == ckp_eff) & (i_sck != ckp_eff);
    assign trail_e = run & ~c.mst & (sckp_q != ckp_eff) & (i_sck == ckp_eff);

    always_comb begin
        samp  = 1'b0;
        shift = 1'b0;
        done  = 1'b0;
        if (st_q == ST_SHIFT) begin
            if (c.mst) begin
                samp  = tick & (h_q == smp_eff); // R9
                shift = tick & h_q & ~last;
                done  = tick & h_q & last;
            end else begin
                samp  = cke_eff ? lead_e : trail_e; // R10 R11
                shift = cke_eff ? trail_e : (lead_e & ~first_q); // R11
                done  = samp & last;
            end
        end
    end

    assign rnext = samp ? {rsh_q[30:0], i_sdi} : rsh_q;
    assign start = run & (st_q == ST_IDLE) & (c.mst ? (qcnt_q != '0) : ~i_ss_n);
    assign pop   = start & (qcnt_q != '0);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_ctrl) begin
            // Locked bits keep their value while the module runs
            ctrl_q <= c.on ? ((i_wdata & CTRL_MASK & ~LOCK_MASK) | (ctrl_q & LOCK_MASK))
                           : (i_wdata & CTRL_MASK); // R12
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            baud_q <= BAUD_RST;
        end else if (i_wr && i_addr == A_BAUD) begin
            baud_q <= i_wdata[15:0];
        end
    end

    // Half-bit divider; counts only on enables from the selected source
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            bcnt_q <= '0;
        end else if (!run || st_q == ST_IDLE) begin
            bcnt_q <= '0;
        end else if (src_en) begin
            bcnt_q <= (bcnt_q == baud_q) ? '0 : bcnt_q + 16'h0001; // R1
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            q_mem[wp_q] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wp_q   <= '0;
            rp_q   <= '0;
            qcnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == QW'(TXQ_DEPTH - 1)) ? '0 : wp_q + QW'(1);
            end
            if (pop) begin
                rp_q <= (rp_q == QW'(TXQ_DEPTH - 1)) ? '0 : rp_q + QW'(1);
            end
            qcnt_q <= qcnt_q + (QW+1)'(push) - (QW+1)'(pop);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q    <= ST_IDLE;
            h_q     <= 1'b0;
            bit_q   <= '0;
            sh_q    <= '0;
            rsh_q   <= '0;
            first_q <= 1'b0;
            ws_q    <= 1'b0;
        end else if (!c.on) begin
            st_q <= ST_IDLE; // R4
            ws_q <= 1'b0;
        end else begin
            rsh_q <= rnext;
            if (tick) begin
                h_q <= ~h_q;
            end
            case (st_q)
                ST_IDLE: begin
                    if (start) begin
                        // Slave with nothing queued answers with zeros
                        sh_q    <= (pop ? q_mem[rp_q] : '0) << (LEN32 - len.dlen);
                        bit_q   <= '0;
                        h_q     <= 1'b0;
                        first_q <= 1'b1;
                        st_q    <= (c.mst && c.frm && !c.aud && !c.fedge) ? ST_PRE : ST_SHIFT; // R2
                    end
                end
                ST_PRE: begin
                    if (tick && h_q) begin
                        st_q <= ST_SHIFT; // R2
                    end
                end
                ST_SHIFT: begin
                    if (!c.mst && i_ss_n) begin
                        st_q <= ST_IDLE;
                    end else if (done) begin
                        st_q <= ST_IDLE;
                        ws_q <= c.aud & ~ws_q; // R7
                    end else begin
                        if (shift) begin
                            sh_q    <= {sh_q[30:0], 1'b0}; // R11
                            first_q <= 1'b0;
                        end
                        if (c.mst ? shift : samp) begin
                            bit_q <= bit_q + 7'h01;
                        end
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_q  <= '0;
            rxf_q <= 1'b0;
        end else if (done) begin
            // Audio channels carry data in their top bits
            rx_q  <= (rnext >> (len.chan - len.dlen)) & dmask; // R7 R8
            rxf_q <= 1'b1;
        end else if (i_rd && i_addr == A_DATA) begin
            rxf_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sckp_q <= 1'b0;
        end else begin
            sckp_q <= i_sck;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pins_q <= '0;
        end else begin
            pins_q.sck    <= ckp_eff ^ ((st_q == ST_SHIFT) & (h_q ? cke_eff : ~cke_eff)); // R15 R11
            pins_q.sck_oe <= c.on & c.mst;
            pins_q.sdo    <= (st_q == ST_SHIFT) & sh_q[31];
            pins_q.sdo_oe <= c.on & ~c.dod; // R6
            pins_q.fs     <= c.aud ? ws_q
                           : c.frm & ((st_q == ST_PRE) | ((st_q == ST_SHIFT) & c.fedge & (bit_q == '0))); // R2
            pins_q.fs_oe  <= c.on & c.mst & (c.frm | c.aud);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_q <= '0;
        end else if (i_rd) begin
            case (i_addr)
                A_CTRL:  rdata_q <= ctrl_q;
                A_DATA:  rdata_q <= rx_q;
                A_BAUD:  rdata_q <= {16'h0000, baud_q};
                A_STAT:  rdata_q <= {28'h0, qcnt_q == '0, qcnt_q >= cap, rxf_q, st_q != ST_IDLE};
                default: rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign o_rdata = rdata_q;
    assign o_pins  = pins_q;

    chk_clock_source: assert property (@(posedge i_clk) disable iff (i_rst) // R1
        c.mclk && !i_ref_clk_en |-> !tick) else $error("baud tick without reference enable");
    chk_frame_lead: assert property (@(posedge i_clk) disable iff (i_rst) // R2
        st_q == ST_PRE && c.on |=> o_pins.fs) else $error("frame pulse missing before first bit");
    chk_enh_depth: assert property (@(posedge i_clk) disable iff (i_rst) // R3
        !c.ebuf && !$past(c.ebuf) |-> qcnt_q <= 1) else $error("queue deeper than one without enhanced buffer");
    chk_off_quiet: assert property (@(posedge i_clk) disable iff (i_rst) // R4
        !c.on |=> st_q == ST_IDLE && !o_pins.sck_oe && !o_pins.sdo_oe) else $error("module active while off");
    chk_idle_freeze: assert property (@(posedge i_clk) disable iff (i_rst) // R5
        halt && c.on && !wr_ctrl |=> $stable(bit_q) && $stable(sh_q) && $stable(st_q)) else $error("engine moved in idle");
    chk_sdo_release: assert property (@(posedge i_clk) disable iff (i_rst) // R6
        c.dod |=> !o_pins.sdo_oe) else $error("data pin driven while released");
    chk_audio_width: assert property (@(posedge i_clk) disable iff (i_rst) // R7
        c.aud && c.w32 |-> len.dlen == 7'd24 && len.chan == 7'd32) else $error("audio width wrong");
    chk_word_len: assert property (@(posedge i_clk) disable iff (i_rst) // R8
        !c.aud && !c.w32 && !c.w16 |-> len.chan == 7'd8) else $error("8-bit word length wrong");
    chk_sample_phase: assert property (@(posedge i_clk) disable iff (i_rst) // R9
        st_q == ST_SHIFT && c.mst && tick && h_q && c.sample_phase |-> samp) else $error("late sample missing");
    chk_lock_bits: assert property (@(posedge i_clk) disable iff (i_rst) // R12
        c.on && wr_ctrl |=> $stable(ctrl_q[B_MCLK]) && $stable(ctrl_q[B_EBUF])) else $error("locked bit changed");
    chk_audio_idle: assert property (@(posedge i_clk) disable iff (i_rst) // R14
        c.aud && st_q == ST_IDLE |=> o_pins.sck) else $error("audio idle clock not high");
    chk_idle_level: assert property (@(posedge i_clk) disable iff (i_rst) // R15
        st_q == ST_IDLE |=> o_pins.sck == $past(ckp_eff)) else $error("idle clock level wrong");
endmodule
`default_nettype wire

// ### spiasc_partner.sv
/*
 Far-side serial device model: samples the data line, shifts out a preset word.
 Assumes the block's pins are registered on the same i_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module spiasc_partner (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_sck,
    input  wire logic        i_sdo,
    input  wire logic        i_fs,
    input  wire logic        i_idle,
    input  wire logic        i_cke,
    input  wire logic        i_load,
    input  wire logic [31:0] i_word,
    output logic             o_sdi,
    output logic [31:0]      o_rx,
    output logic [6:0]       o_cnt,
    output logic             o_fs_first,
    output logic             o_fs_seen
);
    logic        sck_q;
    logic [31:0] tx_q;
    assign o_sdi = tx_q[31];
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sck_q <= 1'b0;
            tx_q <= 32'h0;
            o_rx <= 32'h0;
            o_cnt <= 7'h0;
            o_fs_first <= 1'b0;
            o_fs_seen <= 1'b0;
        end else if (i_load) begin
            tx_q <= i_word;
            o_rx <= 32'h0;
            o_cnt <= 7'h0;
            o_fs_seen <= 1'b0;
            sck_q <= i_sck;
        end else begin
            sck_q <= i_sck;
            if (i_fs) begin
                o_fs_seen <= 1'b1;
            end
            // Sample on the edge opposite to the one that moves data
            if (i_sck != sck_q && (i_sck != i_idle) == i_cke) begin
                o_rx <= {o_rx[30:0], i_sdo};
                o_cnt <= o_cnt + 7'h1;
                if (o_cnt == 7'h0) begin
                    o_fs_first <= i_fs;
                end
            end else if (i_sck != sck_q && o_cnt != 7'h0) begin
                // Inverse shifted in keeps the line moving once the word is spent
                tx_q <= {tx_q[30:0], ~tx_q[0]};
            end
        end
    end
endmodule
`default_nettype wire

// ### test_spi_audio_serial_control.sv
/*
 Self-checking bench for the serial control block with a far-side device model.
 Assumes the package offsets and bit positions; slave inputs are held inactive.
*/
`timescale 1ns/10ps
`default_nettype none
module test_spi_audio_serial_control;
    import spiasc_pkg::*;
    localparam logic [31:0] PW = 32'h6c3a_9e51;
    logic         i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_ref_clk_en = 1'b0;
    logic         i_cpu_idle = 1'b0, p_load = 1'b0, p_idle = 1'b0, p_cke = 1'b0, ref_run = 1'b1;
    logic [3:0]   i_addr = 4'h0;
    logic [31:0]  i_wdata = 32'h0, o_rdata, p_word = 32'h0, p_rx, rdv;
    logic [6:0]   p_cnt;
    logic         p_sdi, p_fs_first, p_fs_seen;
    spiasc_pins_t o_pins;
    int           err_count = 0, cmp_count = 0;
    logic [31:0]  lw [6] = '{32'hffff_feff, 32'h0, 32'h0, 32'h0081_0000, 32'h0081_8000, 32'h0000_8000};
    logic [31:0]  lr [6] = '{CTRL_MASK & 32'hffff_feff, LOCK_MASK, 32'h0, 32'h0081_0000, 32'h0081_8000,
                             32'h0081_8000};

    always #50 i_clk = ~i_clk;
    always @(posedge i_clk) i_ref_clk_en <= ref_run & ~i_ref_clk_en;

    spiasc_core #(.TXQ_DEPTH(4)) spiasc_core_inst (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ref_clk_en(i_ref_clk_en),
        .i_cpu_idle(i_cpu_idle), .i_sck(1'b0), .i_ss_n(1'b1), .i_sdi(p_sdi), .o_pins(o_pins));
    spiasc_partner spiasc_partner_inst (.i_clk(i_clk), .i_rst(i_rst), .i_sck(o_pins.sck),
        .i_sdo(o_pins.sdo), .i_fs(o_pins.fs), .i_idle(p_idle), .i_cke(p_cke), .i_load(p_load),
        .i_word(p_word), .o_sdi(p_sdi), .o_rx(p_rx), .o_cnt(p_cnt), .o_fs_first(p_fs_first),
        .o_fs_seen(p_fs_seen));

    function automatic logic [31:0] bt(input int n);
        return 32'h1 << n;
    endfunction
    function automatic logic [31:0] msk(input int n);
        return (n >= 32) ? 32'hffff_ffff : ((32'h1 << n) - 32'h1);
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        rdv = o_rdata;
    endtask
    // Clock select and buffer bits are only touched with the module off
    task automatic cfg(input logic [31:0] c);
        wr(A_CTRL, 32'h0);
        wr(A_CTRL, c & ~bt(B_ON));
        wr(A_BAUD, 32'h3);
        wr(A_CTRL, c);
        p_idle <= c[B_CKP] | c[B_AUD];
        p_cke <= c[B_CKE];
        // Pins are registered one clock behind the control register
        repeat (2) @(negedge i_clk);
    endtask
    task automatic start(input logic [31:0] d);
        @(posedge i_clk);
        p_word <= PW;
        p_load <= 1'b1;
        @(posedge i_clk);
        p_load <= 1'b0;
        wr(A_DATA, d);
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        rd(A_STAT);
        while (rdv[S_RXF] !== 1'b1 && n < 400) begin
            rd(A_STAT);
            n++;
        end
        chk("word done", {31'h0, rdv[S_RXF]}, 32'h1);
    endtask
    task automatic run_word(input logic [31:0] c, input logic [31:0] d, input int dl, input int cl);
        cfg(c);
        start(d);
        wait_done();
        chk("bits clocked", 32'(p_cnt), cl);
        chk("word on wire", p_rx & msk(cl), (d & msk(dl)) << (cl - dl));
        rd(A_DATA);
        chk("word read", rdv, PW >> (32 - dl));
        chk("clock idle", {31'h0, o_pins.sck}, {31'h0, c[B_CKP] | c[B_AUD]});
    endtask
    task automatic t_reset;
        rd(A_CTRL);
        chk("control reset", rdv, CTRL_RST);
        rd(A_BAUD);
        chk("baud reset", rdv, {16'h0, BAUD_RST});
        rd(A_STAT);
        chk("status reset", rdv, bt(S_TXE));
        rd(4'h1);
        chk("unmapped read", rdv, 32'h0);
        for (int i = 0; i < 6; i++) begin
            wr(A_CTRL, lw[i]);
            rd(A_CTRL);
            chk("control readback", rdv, lr[i]);
        end
    endtask
    task automatic t_pins;
        cfg(bt(B_ON) | bt(B_MST) | bt(B_DOD));
        chk("pin enables released", {30'h0, o_pins.sck_oe, o_pins.sdo_oe}, 32'h2);
        cfg(bt(B_ON) | bt(B_MST));
        chk("pin enables driven", {30'h0, o_pins.sck_oe, o_pins.sdo_oe}, 32'h3);
        wr(A_CTRL, 32'h0);
        repeat (3) @(posedge i_clk);
        chk("pin enables off", {30'h0, o_pins.sck_oe, o_pins.sdo_oe}, 32'h0);
    endtask
    task automatic t_words;
        for (int i = 0; i < 4; i++) begin
            i_cpu_idle <= i[0];
            run_word(bt(B_ON) | bt(B_MST) | (i < 2 ? bt(B_CKE) : 32'h0) | (i[1] ? bt(B_W32) | bt(B_CKP) : 32'h0)
                | (i[0] ? bt(B_W16) | bt(B_SMP) : 32'h0), 32'hc3a5_5a3c, i[1] ? 32 : (i[0] ? 16 : 8),
                i[1] ? 32 : (i[0] ? 16 : 8));
        end
        i_cpu_idle <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            run_word(bt(B_ON) | bt(B_MST) | bt(B_AUD) | bt(B_CKE) | (i == 2 ? bt(B_W32) : 32'h0)
                | (i == 1 ? bt(B_W16) : 32'h0), 32'h008d_e4b7, i == 2 ? 24 : 16, i == 0 ? 16 : 32);
        end
    endtask
    task automatic t_frame;
        for (int i = 0; i < 2; i++) begin
            // Clock edge bit left zero while framed
            cfg(bt(B_ON) | bt(B_MST) | bt(B_FRM) | (i == 1 ? bt(B_FEDGE) : 32'h0));
            start(32'h5a);
            wait_done();
            chk("sync at first bit", {31'h0, p_fs_first}, 32'(i));
            chk("sync seen", {31'h0, p_fs_seen}, 32'h1);
            // Reading the word clears rx full before the next frame
            rd(A_DATA);
            chk("frame word read", rdv, PW >> 24);
        end
    endtask
    task automatic t_stall(input logic [31:0] x);
        cfg(bt(B_ON) | bt(B_MST) | bt(B_CKE) | x);
        ref_run <= 1'b0;
        i_cpu_idle <= x[B_ISTOP];
        start(32'h96);
        repeat (60) @(posedge i_clk);
        rd(A_STAT);
        chk("stalled word", {31'h0, rdv[S_RXF]}, 32'h0);
        ref_run <= 1'b1;
        i_cpu_idle <= 1'b0;
        wait_done();
        chk("bits after stall", 32'(p_cnt), 32'h8);
        rd(A_DATA);
        chk("stall word read", rdv, PW >> 24);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset();
        t_pins();
        t_words();
        t_frame();
        t_stall(bt(B_MCLK));
        t_stall(bt(B_ISTOP));
        print_verdict();
    end
    // Whole run is a few thousand cycles; this leaves ample margin
    initial begin
        #3_000_000;
        err_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
